/* File: reset_seq_cfg.svh */
// Constants for the reset source sequencer: offsets, fields, mode codes and timing counts.
//
// What this block does
// - Brown-out mode from two-bit field: 11 on, 10 off in sleep, 01 software, 00 off.
// - Brown-out resets only when low supply persists beyond the filter time.
// - Always-on: start-up waits ready and supply good; sleep keeps protection, no wake delay.
// - Off-in-sleep: start-up waits ready and supply; sleep disables; wake waits ready.
// - Software mode: enable bit set means detector active, clear means disabled.
// - Software mode: start-up never waits on detector; sleep changes nothing.
// - Protection acts once the detector is ready; a status bit mirrors readiness.
// - Outside software mode the enable bit is read/write but has no effect.
// - Control register: enable at bit 7, set by power-on/brown-out, bits 6-1 read zero.
// - Control register bit 0 is read-only detector-ready status.
// - Pin reset disabled only when pin enable and low-voltage program bits are both 0.
// - Enabled pin held low keeps the device in reset.
// - Pin reset path filters out short pulses.
// - No reset source drives the reset pin low.
// - Pin disabled as reset: general input with software weak pull-up.
// - Watchdog timeout resets and updates the timeout and power-down flags.
// - Reset instruction resets the device and clears its flag to 0.
// - Stack overflow/underflow resets only if enabled; a flag records the cause.
// - Leaving programming mode behaves as a power-on reset.
// - Execution starts after startup timer, oscillator timer and pin release.
// - Timers run regardless of the pin; pin release then starts execution at once.
// - Startup timer gives 64 ms, starts after power-on/brown-out, enabled when bit clear.
`ifndef RESET_SEQ_CFG_SVH
`define RESET_SEQ_CFG_SVH

// ************************************************************
// Register map
// ************************************************************
`define ADDR_BROWNOUT_CONTROL 12'h000
`define ADDR_RESET_CAUSE      12'h004
`define ADDR_CONTROL          12'h008
`define ADDR_STATUS           12'h00C

// ************************************************************
// Field positions
// ************************************************************
`define BC_SW_EN_BIT   7
`define BC_READY_BIT   0
`define RC_OVF_BIT     7
`define RC_UNF_BIT     6
`define RC_PIN_BIT     3
`define RC_RI_BIT      2
`define RC_POR_BIT     1
`define RC_BOR_BIT     0
`define CTL_PULLUP_BIT 0
`define ST_TO_BIT      4
`define ST_PD_BIT      3
`define ST_RUN_BIT     0

// ************************************************************
// Mode codes
// ************************************************************
`define MODE_ON     2'h3
`define MODE_NSLEEP 2'h2
`define MODE_SW     2'h1

// ************************************************************
// Timing
// ************************************************************
`define CLK_HZ            100000000
`define STARTUP_TIME_MS   64
`define STARTUP_CYCLES    ((`CLK_HZ / 1000) * `STARTUP_TIME_MS)
`define BOR_FILTER_NS     1000
`define BOR_FILTER_CYCLES ((`BOR_FILTER_NS * (`CLK_HZ / 1000000)) / 1000)
`define PIN_FILTER_NS     200
`define PIN_FILTER_CYCLES ((`PIN_FILTER_NS * (`CLK_HZ / 1000000)) / 1000)
`define OST_CYCLES_DEF    1024

`endif

/* File: reset_seq_pkg.sv */
// Types for the reset source sequencer.
package reset_seq_pkg;
  typedef logic [1:0] bor_mode_t;
  typedef enum logic [1:0] { SEQ_HOLD, SEQ_WAIT, SEQ_RUN } seq_state_t;
endpackage : reset_seq_pkg

/* File: reset_source_sequencer.sv */
// Reset source sequencer: brown-out mode logic, pin reset filter, reset combining and start-up.
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "reset_seq_cfg.svh"

module reset_source_sequencer #(
  parameter int STARTUP_CYCLES = `STARTUP_CYCLES,
  parameter int OST_CYCLES     = `OST_CYCLES_DEF
) (
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire reset_seq_pkg::bor_mode_t brownout_mode_sel,
  input  wire logic                     startup_delay_enable_n,
  input  wire logic                     ost_required,
  input  wire logic                     ext_reset_pin_enable,
  input  wire logic                     low_volt_program_enable,
  input  wire logic                     stack_reset_enable,
  input  wire logic                     sleep_mode,
  input  wire logic                     brownout_circuit_ready,
  input  wire logic                     supply_below_threshold,
  input  wire logic                     ext_reset_pin_in,
  input  wire logic                     watchdog_timeout,
  input  wire logic                     reset_instr,
  input  wire logic                     stack_overflow,
  input  wire logic                     stack_underflow,
  input  wire logic                     program_mode_exit,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  output logic                          brownout_enable,
  output logic                          brownout_ready,
  output logic                          ext_reset_pin_out,
  output logic                          ext_reset_pin_oe,
  output logic                          ext_reset_pin_pullup,
  output logic                          gpio_in,
  output logic                          core_reset
);
  import reset_seq_pkg::*;

  // ************************************************************
  // Brown-out detector mode
  // ************************************************************
  logic       sw_brownout_enable_q;
  logic       bor_active;
  logic       pin_enabled;
  logic       wait_bor;
  // Decide whether the detector runs for the current mode and sleep state.
  always_comb begin
    case (brownout_mode_sel)
      `MODE_ON:     bor_active = 1'b1;
      `MODE_NSLEEP: bor_active = !sleep_mode;
      `MODE_SW:     bor_active = sw_brownout_enable_q;
      default:      bor_active = 1'b0;
    endcase
  end
  // Modes that hold start-up or wake-up on detector readiness.
  assign wait_bor = (brownout_mode_sel == `MODE_ON) || (brownout_mode_sel == `MODE_NSLEEP);
  assign pin_enabled = ext_reset_pin_enable || low_volt_program_enable;

  // ************************************************************
  // Brown-out filter
  // ************************************************************
  logic [15:0] bor_cnt_q;
  logic        bor_event;
  // Count how long the supply stays low while the detector is ready and active.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bor_cnt_q <= 16'h0000;
    end else if (bor_active && brownout_circuit_ready && supply_below_threshold) begin
      if (bor_cnt_q <= 16'(`BOR_FILTER_CYCLES)) begin
        bor_cnt_q <= bor_cnt_q + 16'h0001;
      end
    end else begin
      bor_cnt_q <= 16'h0000;
    end
  end
  assign bor_event = (bor_cnt_q > 16'(`BOR_FILTER_CYCLES));

  // ************************************************************
  // Reset pin filter
  // ************************************************************
  logic [7:0] pin_cnt_q;
  logic       pin_low_q;
  // Accept a new pin level only after it holds for the filter time.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_cnt_q <= 8'h00;
      pin_low_q <= 1'b0;
    end else if ((!ext_reset_pin_in) == pin_low_q) begin
      pin_cnt_q <= 8'h00;
    end else if (pin_cnt_q >= 8'(`PIN_FILTER_CYCLES)) begin
      pin_cnt_q <= 8'h00;
      pin_low_q <= !ext_reset_pin_in;
    end else begin
      pin_cnt_q <= pin_cnt_q + 8'h01;
    end
  end

  // ************************************************************
  // Reset combining and release
  // ************************************************************
  logic por_like;
  logic warm_src;
  logic rst_req;
  logic rst_sync1_q;
  logic rst_sync2_q;
  assign por_like = bor_event || program_mode_exit;
  assign warm_src = watchdog_timeout || reset_instr
                    || (stack_reset_enable && (stack_overflow || stack_underflow));
  assign rst_req  = reset || por_like || warm_src;
  // Assert at once on any source, release two clock edges after the last one.
  always_ff @(posedge clk or posedge rst_req) begin
    if (rst_req) begin
      rst_sync1_q <= 1'b1;
      rst_sync2_q <= 1'b1;
    end else begin
      rst_sync1_q <= 1'b0;
      rst_sync2_q <= rst_sync1_q;
    end
  end

  // ************************************************************
  // Start-up sequencer
  // ************************************************************
  seq_state_t  state_q;
  logic [31:0] startup_delay_timer_cnt_q;
  logic [31:0] ost_cnt_q;
  logic        timers_done;
  logic        cold_q;
  logic        sleep_q;
  assign timers_done = (startup_delay_enable_n || (startup_delay_timer_cnt_q >= 32'(STARTUP_CYCLES)))
                       && (!ost_required || (ost_cnt_q >= 32'(OST_CYCLES)));
  // Remember whether the pending release follows a power-on or brown-out.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cold_q <= 1'b1;
    end else if (por_like) begin
      cold_q <= 1'b1;
    end else if (state_q == SEQ_RUN) begin
      cold_q <= 1'b0;
    end
  end
  // Run the timers after a cold release, independent of the pin.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      startup_delay_timer_cnt_q <= 32'h00000000;
      ost_cnt_q  <= 32'h00000000;
    end else if (rst_sync2_q || por_like) begin
      startup_delay_timer_cnt_q <= 32'h00000000;
      ost_cnt_q  <= 32'h00000000;
    end else if (!cold_q) begin
      startup_delay_timer_cnt_q <= 32'(STARTUP_CYCLES);
      ost_cnt_q  <= 32'(OST_CYCLES);
    end else begin
      if (startup_delay_timer_cnt_q < 32'(STARTUP_CYCLES)) begin
        startup_delay_timer_cnt_q <= startup_delay_timer_cnt_q + 32'h00000001;
      end
      if (ost_cnt_q < 32'(OST_CYCLES)) begin
        ost_cnt_q <= ost_cnt_q + 32'h00000001;
      end
    end
  end
  // Track the sleep edge so an off-in-sleep wake waits on readiness.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sleep_q <= 1'b0;
    end else begin
      sleep_q <= sleep_mode;
    end
  end
  // Hold the core until every release condition is met.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= SEQ_HOLD;
    end else if (rst_sync2_q || (pin_enabled && pin_low_q)) begin
      state_q <= SEQ_HOLD;
    end else begin
      case (state_q)
        SEQ_HOLD: state_q <= SEQ_WAIT;
        SEQ_WAIT: begin
          if (timers_done && ((!cold_q && (brownout_circuit_ready || (brownout_mode_sel != `MODE_NSLEEP)))
              || !wait_bor || (brownout_circuit_ready && !supply_below_threshold))) begin
            state_q <= SEQ_RUN;
          end
        end
        SEQ_RUN: begin
          if (sleep_q && !sleep_mode && (brownout_mode_sel == `MODE_NSLEEP)
              && !brownout_circuit_ready) begin
            state_q <= SEQ_WAIT;
          end
        end
        default: state_q <= SEQ_HOLD;
      endcase
    end
  end

  // ************************************************************
  // Reset cause flags
  // ************************************************************
  logic       ovf_q;
  logic       unf_q;
  logic       pin_flag_q;
  logic       ri_q;
  logic       por_n_q;
  logic       bor_n_q;
  logic       to_q;
  logic       pd_q;
  logic       wr_en;
  logic       wr_cause;
  logic       wr_bc;
  assign wr_en    = psel && penable && pwrite;
  assign wr_cause = wr_en && (paddr == `ADDR_RESET_CAUSE);
  assign wr_bc    = wr_en && (paddr == `ADDR_BROWNOUT_CONTROL);
  // Hardware events win over a software write in the same cycle.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ovf_q      <= 1'b0;
      unf_q      <= 1'b0;
      pin_flag_q <= 1'b1;
      ri_q       <= 1'b1;
      por_n_q    <= 1'b0;
      bor_n_q    <= 1'b0;
      to_q       <= 1'b1;
      pd_q       <= 1'b1;
    end else begin
      if (wr_cause) begin
        ovf_q      <= pwdata[`RC_OVF_BIT];
        unf_q      <= pwdata[`RC_UNF_BIT];
        pin_flag_q <= pwdata[`RC_PIN_BIT];
        ri_q       <= pwdata[`RC_RI_BIT];
        por_n_q    <= pwdata[`RC_POR_BIT];
        bor_n_q    <= pwdata[`RC_BOR_BIT];
      end
      if (stack_reset_enable && stack_overflow) begin
        ovf_q <= 1'b1;
      end
      if (stack_reset_enable && stack_underflow) begin
        unf_q <= 1'b1;
      end
      if (pin_enabled && pin_low_q) begin
        pin_flag_q <= 1'b0;
      end
      if (reset_instr) begin
        ri_q <= 1'b0;
      end
      if (watchdog_timeout) begin
        to_q <= 1'b0;
        pd_q <= !sleep_mode;
      end else if (sleep_mode) begin
        pd_q <= 1'b0;
      end
      if (program_mode_exit) begin
        ovf_q <= 1'b0;
        unf_q <= 1'b0;
        pin_flag_q <= 1'b1;
        ri_q <= 1'b1;
        por_n_q <= 1'b0;
        bor_n_q <= 1'b0;
        to_q <= 1'b1;
        pd_q <= 1'b1;
      end else if (bor_event) begin
        ovf_q <= 1'b0;
        unf_q <= 1'b0;
        pin_flag_q <= 1'b1;
        ri_q <= 1'b1;
        bor_n_q <= 1'b0;
        to_q <= 1'b1;
        pd_q <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Software registers
  // ************************************************************
  logic pullup_q;
  // Enable bit is set by power-on or brown-out, kept on other resets.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sw_brownout_enable_q <= 1'b1;
      pullup_q             <= 1'b0;
    end else begin
      if (por_like) begin
        sw_brownout_enable_q <= 1'b1;
      end else if (wr_bc) begin
        sw_brownout_enable_q <= pwdata[`BC_SW_EN_BIT];
      end
      if (wr_en && (paddr == `ADDR_CONTROL)) begin
        pullup_q <= pwdata[`CTL_PULLUP_BIT];
      end
    end
  end

  // ************************************************************
  // APB slave, one wait-free access phase
  // ************************************************************
  logic [31:0] rdata;
  logic        mapped;
  // Decode read data; unmapped addresses read zero and answer an error.
  always_comb begin
    rdata  = 32'h00000000;
    mapped = 1'b1;
    case (paddr)
      `ADDR_BROWNOUT_CONTROL: begin
        rdata[`BC_SW_EN_BIT] = sw_brownout_enable_q;
        rdata[`BC_READY_BIT] = brownout_ready;
      end
      `ADDR_RESET_CAUSE: begin
        rdata[`RC_OVF_BIT] = ovf_q;
        rdata[`RC_UNF_BIT] = unf_q;
        rdata[`RC_PIN_BIT] = pin_flag_q;
        rdata[`RC_RI_BIT]  = ri_q;
        rdata[`RC_POR_BIT] = por_n_q;
        rdata[`RC_BOR_BIT] = bor_n_q;
      end
      `ADDR_CONTROL: rdata[`CTL_PULLUP_BIT] = pullup_q;
      `ADDR_STATUS: begin
        rdata[`ST_TO_BIT]  = to_q;
        rdata[`ST_PD_BIT]  = pd_q;
        rdata[`ST_RUN_BIT] = (state_q == SEQ_RUN);
      end
      default: mapped = 1'b0;
    endcase
  end
  // Answer in the first access cycle.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= (psel && !penable && !pwrite) ? rdata : 32'h00000000;
    end
  end

  // ************************************************************
  // Registered outputs
  // ************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      brownout_enable      <= 1'b0;
      brownout_ready       <= 1'b0;
      ext_reset_pin_out    <= 1'b0;
      ext_reset_pin_oe     <= 1'b0;
      ext_reset_pin_pullup <= 1'b1;
      gpio_in              <= 1'b0;
      core_reset           <= 1'b1;
    end else begin
      brownout_enable      <= bor_active;
      brownout_ready       <= bor_active && brownout_circuit_ready;
      ext_reset_pin_out    <= 1'b0;
      ext_reset_pin_oe     <= 1'b0;
      ext_reset_pin_pullup <= pin_enabled ? 1'b1 : pullup_q;
      gpio_in              <= pin_enabled ? 1'b0 : ext_reset_pin_in;
      core_reset           <= (state_q != SEQ_RUN);
    end
  end
endmodule : reset_source_sequencer

/* File: reset_source_sequencer_assertions.sv */
// Concurrent checks on the ports of the reset source sequencer.
`timescale 1ns/1ps
`include "reset_seq_cfg.svh"

module reset_source_sequencer_assertions (
  input wire logic                     clk,
  input wire logic                     reset,
  input wire reset_seq_pkg::bor_mode_t brownout_mode_sel,
  input wire logic                     sleep_mode,
  input wire logic                     ext_reset_pin_enable,
  input wire logic                     low_volt_program_enable,
  input wire logic                     stack_reset_enable,
  input wire logic                     supply_below_threshold,
  input wire logic                     brownout_circuit_ready,
  input wire logic                     ext_reset_pin_in,
  input wire logic                     watchdog_timeout,
  input wire logic                     reset_instr,
  input wire logic                     stack_overflow,
  input wire logic                     program_mode_exit,
  input wire logic                     brownout_enable,
  input wire logic                     brownout_ready,
  input wire logic                     ext_reset_pin_out,
  input wire logic                     ext_reset_pin_oe,
  input wire logic                     ext_reset_pin_pullup,
  input wire logic                     gpio_in,
  input wire logic                     core_reset
);
  import reset_seq_pkg::*;
  logic       pin_on;
  logic [7:0] pin_cnt_q;
  logic [7:0] dip_cnt_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // The pin acts as a reset input when either enable is high.
  assign pin_on = ext_reset_pin_enable | low_volt_program_enable;

  // Counts consecutive cycles of an enabled pin held low, saturating.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) pin_cnt_q <= 8'h00;
    else if (!(pin_on && !ext_reset_pin_in)) pin_cnt_q <= 8'h00;
    else if (pin_cnt_q != 8'hFF) pin_cnt_q <= pin_cnt_q + 8'h01;
  end

  // Counts consecutive cycles of low supply while protection is armed.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) dip_cnt_q <= 8'h00;
    else if (!(supply_below_threshold && brownout_ready)) dip_cnt_q <= 8'h00;
    else if (dip_cnt_q != 8'hFF) dip_cnt_q <= dip_cnt_q + 8'h01;
  end

  AST_PIN_INPUT_ONLY: assert property (!ext_reset_pin_oe && !ext_reset_pin_out) else $error("pin driven");
  AST_PIN_HOLD: assert property (pin_cnt_q == 8'h1E |-> ##[0:4] core_reset) else $error("pin low, no hold");
  AST_BOR_TRIP: assert property (dip_cnt_q == 8'h78 |-> ##[0:4] core_reset) else $error("dip, no hold");
  AST_WDT_HOLD: assert property (watchdog_timeout |-> ##[0:2] core_reset) else $error("watchdog, no hold");
  AST_RI_HOLD: assert property (reset_instr |-> ##[0:2] core_reset) else $error("instr, no hold");
  AST_STACK_HOLD: assert property (stack_overflow && stack_reset_enable |-> ##[0:2] core_reset)
    else $error("stack, no hold");
  AST_PROG_EXIT: assert property ($rose(program_mode_exit) |-> ##2 core_reset [*3]) else $error("exit, no hold");
  AST_PULLUP: assert property (pin_on |=> ext_reset_pin_pullup) else $error("pull-up off");
  AST_GPIO_QUIET: assert property (pin_on |=> !gpio_in) else $error("gpio active");
  AST_READY_SRC: assert property ($rose(brownout_ready) |-> $past(brownout_circuit_ready))
    else $error("ready without detector");
  AST_MODE_ON: assert property (brownout_mode_sel == `MODE_ON |=> brownout_enable) else $error("mode on idle");
  AST_MODE_OFF: assert property (brownout_mode_sel == 2'h0 |=> !brownout_enable) else $error("mode off active");
  AST_NSLEEP: assert property (brownout_mode_sel == `MODE_NSLEEP && sleep_mode |=> !brownout_enable)
    else $error("sleep active");
endmodule : reset_source_sequencer_assertions

bind reset_source_sequencer reset_source_sequencer_assertions u_reset_source_sequencer_assertions (
  .clk, .reset, .brownout_mode_sel, .sleep_mode, .ext_reset_pin_enable, .low_volt_program_enable,
  .stack_reset_enable, .supply_below_threshold, .brownout_circuit_ready, .ext_reset_pin_in,
  .watchdog_timeout, .reset_instr, .stack_overflow, .program_mode_exit, .brownout_enable, .brownout_ready,
  .ext_reset_pin_out, .ext_reset_pin_oe, .ext_reset_pin_pullup, .gpio_in, .core_reset);

/* File: supply_pin_model.sv */
// Model of the supply comparator and the external reset pin.
`timescale 1ns/1ps

module supply_pin_model #(
  parameter int READY_DLY = 6
) (
  input  wire logic clk,
  input  wire logic detector_on,
  input  wire logic supply_low,
  input  wire logic pin_low,
  input  wire logic pin_pullup,
  output logic      detector_ready,
  output logic      supply_below,
  output logic      pin_level
);
  logic [3:0] warm_q = 4'h0;

  initial detector_ready = 1'b0;
  initial pin_level = 1'b1;

  // The comparator settles some cycles after it is switched on.
  always @(posedge clk) begin
    warm_q <= !detector_on ? 4'h0 : (warm_q == READY_DLY[3:0]) ? warm_q : warm_q + 4'h1;
    detector_ready <= detector_on && (warm_q == READY_DLY[3:0]);
    supply_below <= supply_low;
  end

  // A pin pulled low resets; released with no pull-up it floats and wanders.
  always @(posedge clk) pin_level <= pin_low ? 1'b0 : (pin_pullup | ~pin_level);
endmodule : supply_pin_model

/* File: test_reset_source_sequencer.sv */
// Self-checking bench for the reset source sequencer.
`timescale 1ns/1ps
`include "reset_seq_cfg.svh"

module test_reset_source_sequencer;
  import reset_seq_pkg::*;
  localparam logic [3:0] CFG [7] = '{4'h4, 4'h5, 4'hC, 4'hE, 4'hA, 4'h8, 4'h1};
  localparam logic [7:0] EXP [7] = '{8'h00, 8'h81, 8'h01, 8'h01, 8'h00, 8'h01, 8'h80};
  localparam logic [7:0] SMASK [6] = '{8'h10, 8'h04, 8'h80, 8'h40, 8'h02, 8'h80};
  localparam logic [7:0] SEXP [6] = '{8'h00, 8'h00, 8'h80, 8'h40, 8'h00, 8'h00};
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, sleep_mode = 0;
  logic startup_delay_enable_n = 0, ost_required = 1, ext_reset_pin_enable = 1, low_volt_program_enable = 0;
  logic stack_reset_enable = 1, watchdog_timeout = 0, reset_instr = 0, stack_overflow = 0, stack_underflow = 0;
  logic program_mode_exit = 0, supply_low = 0, pin_low = 1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  bor_mode_t brownout_mode_sel = 2'h1;
  logic pready, pslverr, brownout_enable, brownout_ready, ext_reset_pin_out, ext_reset_pin_oe;
  logic ext_reset_pin_pullup, gpio_in, core_reset, brownout_circuit_ready, supply_below_threshold;
  logic ext_reset_pin_in;
  int mismatches = 0, total_checks = 0, cycles = 0;

  reset_source_sequencer #(.STARTUP_CYCLES(50), .OST_CYCLES(8)) u_reset_source_sequencer (
    .clk, .reset, .brownout_mode_sel, .startup_delay_enable_n, .ost_required, .ext_reset_pin_enable,
    .low_volt_program_enable, .stack_reset_enable, .sleep_mode, .brownout_circuit_ready, .supply_below_threshold,
    .ext_reset_pin_in, .watchdog_timeout, .reset_instr, .stack_overflow, .stack_underflow, .program_mode_exit,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .brownout_enable, .brownout_ready,
    .ext_reset_pin_out, .ext_reset_pin_oe, .ext_reset_pin_pullup, .gpio_in, .core_reset);

  supply_pin_model u_supply_pin_model (.clk, .detector_on(brownout_enable), .supply_low, .pin_low,
    .pin_pullup(ext_reset_pin_pullup), .detector_ready(brownout_circuit_ready),
    .supply_below(supply_below_threshold), .pin_level(ext_reset_pin_in));

  // Clock and a cycle ceiling that cuts a hang short.
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; waits for pready and takes the answer at that edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) mismatches++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Waits for the core to run, counting the cycles taken.
  task automatic wait_run(input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (core_reset !== 1'b0 && n < lim);
    if (n == lim) mismatches++;
  endtask : wait_run

  task automatic s_startup();
    logic [31:0] q;
    logic e;
    int n;
    repeat (100) @(posedge clk);
    check(32'(core_reset), 32'h1);
    pin_low <= 1'b0;
    wait_run(100, n);
    check(32'(n <= 30), 32'h1);
    apb(1'b0, `ADDR_BROWNOUT_CONTROL, 32'h0, q, e);
    check(q, 32'h81);
  endtask : s_startup

  task automatic s_modes();
    logic [31:0] q;
    logic e;
    int n;
    for (int i = 0; i < 7; i++) begin
      brownout_mode_sel <= CFG[i][3:2];
      sleep_mode <= CFG[i][1];
      apb(1'b1, `ADDR_BROWNOUT_CONTROL, {24'h0, CFG[i][0], 7'h7F}, q, e);
      repeat (15) @(posedge clk);
      if (i == 0) check(32'(core_reset), 32'h0);
      wait_run(100, n);
      apb(1'b0, `ADDR_BROWNOUT_CONTROL, 32'h0, q, e);
      check(q, {24'h0, EXP[i]});
    end
    sleep_mode <= 1'b0;
  endtask : s_modes

  task automatic s_bor();
    logic [31:0] q;
    logic e;
    logic hit;
    int n;
    brownout_mode_sel <= `MODE_ON;
    apb(1'b1, `ADDR_BROWNOUT_CONTROL, 32'h0, q, e);
    repeat (15) @(posedge clk);
    for (int len = 60; len <= 140; len += 80) begin
      hit = 1'b0;
      supply_low <= 1'b1;
      repeat (len) begin
        @(posedge clk);
        hit |= core_reset;
      end
      supply_low <= 1'b0;
      check(32'(hit), 32'(len > 100));
      wait_run(200, n);
    end
    apb(1'b0, `ADDR_BROWNOUT_CONTROL, 32'h0, q, e);
    check(q, 32'h81);
  endtask : s_bor

  task automatic s_sources();
    logic [31:0] q;
    logic e;
    int n;
    for (int k = 0; k < 6; k++) begin
      stack_reset_enable <= (k != 5);
      apb(1'b1, `ADDR_RESET_CAUSE, 32'h0F, q, e);
      watchdog_timeout <= (k == 0);
      reset_instr <= (k == 1);
      stack_overflow <= (k == 2 || k == 5);
      stack_underflow <= (k == 3);
      program_mode_exit <= (k == 4);
      @(posedge clk);
      {watchdog_timeout, reset_instr, stack_overflow, stack_underflow, program_mode_exit} <= 5'h00;
      repeat (2) @(negedge clk);
      check(32'(core_reset), 32'(k != 5));
      wait_run(150, n);
      check(32'(n > 50), 32'(k == 4));
      apb(1'b0, (k == 0) ? `ADDR_STATUS : `ADDR_RESET_CAUSE, 32'h0, q, e);
      check(q & {24'h0, SMASK[k]}, {24'h0, SEXP[k]});
    end
  endtask : s_sources

  task automatic s_pin();
    logic [31:0] q;
    logic e;
    logic hit;
    hit = 1'b0;
    pin_low <= 1'b1;
    repeat (38) begin
      @(posedge clk);
      pin_low <= 1'b0;
      hit |= core_reset;
    end
    check(32'(hit), 32'h0);
    ext_reset_pin_enable <= 1'b0;
    low_volt_program_enable <= 1'b1;
    apb(1'b1, `ADDR_CONTROL, 32'h0, q, e);
    repeat (3) @(posedge clk);
    check(32'(ext_reset_pin_pullup), 32'h1);
    low_volt_program_enable <= 1'b0;
    repeat (3) @(posedge clk);
    check(32'(ext_reset_pin_pullup), 32'h0);
    apb(1'b1, `ADDR_CONTROL, 32'h1, q, e);
    pin_low <= 1'b1;
    repeat (40) begin
      @(posedge clk);
      hit |= core_reset;
    end
    check(32'(gpio_in), 32'h0);
    check(32'(hit), 32'h0);
    pin_low <= 1'b0;
    repeat (5) @(posedge clk);
    check(32'(gpio_in), 32'h1);
    ext_reset_pin_enable <= 1'b1;
  endtask : s_pin

  task automatic s_unmapped();
    logic [31:0] q;
    logic e;
    apb(1'b0, 12'h010, 32'h0, q, e);
    check(q, 32'h0);
    check(32'(e), 32'h1);
  endtask : s_unmapped
  // Main sequence.
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    s_startup();
    s_modes();
    s_bor();
    s_sources();
    s_pin();
    s_unmapped();
    conclude();
  end
endmodule : test_reset_source_sequencer
